// [csm_consts.svh]
// Purpose: Constants for the CPU sleep mode controller.
// Assumes: Included by bare name.
// Notes: Definitions only.
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
`define CSM_IRQ_W 4
`define CSM_SYNC_STAGES 2
`endif

// [csm_pkg.sv]
// Purpose: Types for the CPU sleep mode controller.
// Assumes: Nothing.
// Notes: Power state encoding.
package csm_pkg;
	typedef enum logic [1:0] {
		CSM_RUN = 2'b00,
		CSM_SLEEP = 2'b01,
		CSM_STANDBY = 2'b10
	} csm_state_t;
	typedef struct packed {
		logic core_run;
		logic periph_clk_en;
		logic core_reset;
		logic vector_take;
	} csm_ctrl_t;
endpackage

// [csm_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: One clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module csm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// [csm_sleep_ctrl.sv]
// Purpose: CPU sleep and standby control.
// Assumes: Interrupt requests arrive ungated; each is gated here by its irq_en bit.
// Notes: Pins pass two flip-flops before use.
`timescale 1ns/10ps
`include "csm_consts.svh"
module csm_sleep_ctrl #(
	parameter int IRQ_W = `CSM_IRQ_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sleep_instruction,
	input wire logic irq_mask,
	input wire logic [IRQ_W-1:0] irq_req,
	input wire logic [IRQ_W-1:0] irq_en,
	input wire logic low_power_hold_pin_n,
	output logic sleeping,
	output logic standby,
	output logic core_run,
	output logic periph_clk_en,
	output logic core_reset,
	output logic vector_take
);
	generate
		if (IRQ_W < 1) begin : g_bad_irq_w
			$error("IRQ_W must be at least 1");
		end
	endgenerate

	// Only the synchronised copies of the pin and the requests are read below.
	logic hold_pin_s;
	logic [IRQ_W-1:0] irq_s;
	csm_pkg::csm_state_t state_q;
	csm_pkg::csm_ctrl_t ctrl_q;
	logic wake_req;
	logic [IRQ_W-1:0] irq_gated;

	// The pin copy resets to its idle high level, so releasing reset never looks like a standby request.
	csm_sync #(.W(1), .RST_VAL(1'b1)) u_hold_sync (
		.clk(clk),
		.rstn(rstn),
		.d(low_power_hold_pin_n),
		.q(hold_pin_s)
	);
	csm_sync #(.W(IRQ_W), .RST_VAL('0)) u_irq_sync (
		.clk(clk),
		.rstn(rstn),
		.d(irq_req),
		.q(irq_s)
	);

	// Gating by the source's own enable means a disabled timer never asks for wake.
	for (genvar i = 0; i < IRQ_W; i++) begin : g_gate
		assign irq_gated[i] = irq_s[i] & irq_en[i];
	end
	assign wake_req = |irq_gated;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= csm_pkg::CSM_RUN;
		end else begin
			unique case (state_q)
				csm_pkg::CSM_RUN: begin
					if (!hold_pin_s) begin
						state_q <= csm_pkg::CSM_STANDBY;
					end else if (sleep_instruction) begin
						state_q <= csm_pkg::CSM_SLEEP;
					end
				end
				csm_pkg::CSM_SLEEP: begin
					if (!hold_pin_s) begin
						state_q <= csm_pkg::CSM_STANDBY;
					end else if (wake_req) begin
						state_q <= csm_pkg::CSM_RUN;
					end
				end
				csm_pkg::CSM_STANDBY: begin
					// Only reset leaves standby; interrupts are ignored here.
					state_q <= csm_pkg::CSM_STANDBY;
				end
				default: begin
					state_q <= csm_pkg::CSM_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= '{core_run: 1'b0, periph_clk_en: 1'b1, core_reset: 1'b1, vector_take: 1'b0};
		end else begin
			ctrl_q.core_run <= 1'b0;
			ctrl_q.periph_clk_en <= 1'b1;
			ctrl_q.core_reset <= 1'b0;
			ctrl_q.vector_take <= 1'b0;
			unique case (state_q)
				csm_pkg::CSM_RUN: begin
					ctrl_q.core_run <= hold_pin_s && !sleep_instruction;
					ctrl_q.core_reset <= !hold_pin_s;
					ctrl_q.periph_clk_en <= hold_pin_s;
				end
				csm_pkg::CSM_SLEEP: begin
					if (!hold_pin_s) begin
						ctrl_q.core_reset <= 1'b1;
						ctrl_q.periph_clk_en <= 1'b0;
					end else if (wake_req) begin
						ctrl_q.core_run <= 1'b1;
						// A masked request resumes after the sleep instruction.
						ctrl_q.vector_take <= !irq_mask;
					end
					// Peripheral clocks stay on while the core is halted.
				end
				csm_pkg::CSM_STANDBY: begin
					ctrl_q.core_reset <= 1'b1;
					ctrl_q.periph_clk_en <= 1'b0;
				end
				default: begin
					ctrl_q.core_reset <= 1'b1;
				end
			endcase
		end
	end

	assign sleeping = (state_q == csm_pkg::CSM_SLEEP);
	assign standby = (state_q == csm_pkg::CSM_STANDBY);
	assign core_run = ctrl_q.core_run;
	assign periph_clk_en = ctrl_q.periph_clk_en;
	assign core_reset = ctrl_q.core_reset;
	assign vector_take = ctrl_q.vector_take;

	property p_sleep_enter;
		@(posedge clk) disable iff (!rstn)
		(state_q == csm_pkg::CSM_RUN && hold_pin_s && sleep_instruction) |=> sleeping;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

	property p_halt;
		@(posedge clk) disable iff (!rstn)
		$past(sleeping) && sleeping |-> !core_run;
	endproperty
	a_halt: assert property (p_halt) else $error("core ran while asleep");

	property p_periph;
		@(posedge clk) disable iff (!rstn)
		sleeping && $past(sleeping) |-> periph_clk_en;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral clock stopped in sleep");

	property p_stay;
		@(posedge clk) disable iff (!rstn)
		sleeping && hold_pin_s && !wake_req |=> sleeping;
	endproperty
	a_stay: assert property (p_stay) else $error("sleep left without cause");

	property p_standby_in;
		@(posedge clk) disable iff (!rstn)
		sleeping && !hold_pin_s |=> standby && core_reset && !periph_clk_en;
	endproperty
	a_standby_in: assert property (p_standby_in) else $error("standby not entered");

	sequence s_wake(m);
		sleeping && hold_pin_s && wake_req && irq_mask == m;
	endsequence
	property p_vec;
		@(posedge clk) disable iff (!rstn)
		s_wake(1'b0) |=> core_run && vector_take && !sleeping;
	endproperty
	a_vec: assert property (p_vec) else $error("wake without vector");

	property p_nomask;
		@(posedge clk) disable iff (!rstn)
		s_wake(1'b1) |=> core_run && !vector_take;
	endproperty
	a_nomask: assert property (p_nomask) else $error("masked wake vectored");

	property p_disabled;
		@(posedge clk) disable iff (!rstn)
		sleeping && hold_pin_s && ((irq_s & irq_en) == '0) |=> sleeping;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled source woke core");

	property p_standby_hold;
		@(posedge clk) disable iff (!rstn)
		standby |=> standby [*2];
	endproperty
	a_standby_hold: assert property (p_standby_hold) else $error("standby left without reset");

	property p_reset_clear;
		@(posedge clk)
		!rstn |=> !sleeping && !standby && core_reset;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear sleep");

	property p_vec_pulse;
		@(posedge clk) disable iff (!rstn)
		vector_take |=> !vector_take;
	endproperty
	// The vector request is a single strobe; a second cycle would enter the handler twice.
	a_vec_pulse: assert property (p_vec_pulse) else $error("vector request longer than one cycle");

	property p_run_standby;
		@(posedge clk) disable iff (!rstn)
		(state_q == csm_pkg::CSM_RUN) && !hold_pin_s |=> standby && core_reset && !periph_clk_en;
	endproperty
	a_run_standby: assert property (p_run_standby) else $error("standby not entered from run");

	property p_standby_out;
		@(posedge clk) disable iff (!rstn)
		standby |-> core_reset && !periph_clk_en && !core_run;
	endproperty
	a_standby_out: assert property (p_standby_out) else $error("core or clocks active in standby");
endmodule

// [csm_far_model.sv]
// Purpose: Peripheral requests and standby pin facing the sleep controller.
// Assumes: Sources are registered on clk.
// Notes: Levels follow the bench commands one cycle late.
`timescale 1ns/10ps
module csm_far_model (
	input wire logic clk,
	input wire logic [3:0] raise,
	input wire logic hold_n,
	output logic [3:0] irq_req,
	output logic pin_n
);
	// A real peripheral gates its request with its own enable; the bench does that through irq_en.
	always_ff @(posedge clk) begin
		irq_req <= raise;
		pin_n <= hold_n;
	end
endmodule

// [test_cpu_sleep_mode_control.sv]
// Purpose: Self-checking bench for the sleep controller.
// Assumes: Latencies of one far-model flop, two sync flops plus one state edge.
// Notes: Outputs are compared as one six-bit word.
`timescale 1ns/10ps
module test_cpu_sleep_mode_control;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic si = 1'b0;
	logic mask = 1'b0;
	logic hold_n = 1'b1;
	logic [3:0] raise = 4'h0;
	logic [3:0] en = 4'h0;
	logic [3:0] irq;
	logic pin_n;
	logic sl, sb, cr, pc, rs, vt;
	logic [5:0] o;
	int failures = 0;
	int check_count = 0;
	assign o = {sl, sb, cr, pc, rs, vt};
	always #12.5 clk = ~clk;
	csm_far_model far (.clk(clk), .raise(raise), .hold_n(hold_n), .irq_req(irq), .pin_n(pin_n));
	csm_sleep_ctrl dut (.clk(clk), .rstn(rstn), .sleep_instruction(si), .irq_mask(mask), .irq_req(irq),
		.irq_en(en), .low_power_hold_pin_n(pin_n), .sleeping(sl), .standby(sb), .core_run(cr),
		.periph_clk_en(pc), .core_reset(rs), .vector_take(vt));
	task chk(input string n, input logic [5:0] e);
		check_count++;
		if (o !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, o);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task go_sleep;
		@(posedge clk) si <= 1'b1;
		@(posedge clk) si <= 1'b0;
		#1 chk("sleep", 6'h24);
	endtask
	// The wake edge is exact: request register edge plus two sync stages plus the state edge.
	task wake(input logic m, input logic [3:0] b, input logic [5:0] e);
		@(posedge clk) begin
			mask <= m;
			en <= b;
			raise <= b;
		end
		cyc(3);
		chk("pre_wake", 6'h24);
		cyc(1);
		chk("wake", e);
		@(posedge clk) raise <= 4'h0;
		#1 chk("after_wake", 6'h0C);
		cyc(3);
	endtask
	task do_reset;
		@(posedge clk) rstn <= 1'b0;
		cyc(1);
		chk("reset", 6'h06);
		@(posedge clk) rstn <= 1'b1;
		cyc(1);
		chk("run", 6'h0C);
	endtask
	// Standby straight from run, then a sleep strobe that standby must refuse.
	task run_standby;
		@(posedge clk) hold_n <= 1'b0;
		cyc(3);
		chk("pre_run_standby", 6'h0C);
		cyc(1);
		chk("run_standby", 6'h12);
		@(posedge clk) begin
			hold_n <= 1'b1;
			si <= 1'b1;
		end
		@(posedge clk) si <= 1'b0;
		#1 chk("standby_no_sleep", 6'h12);
	endtask
	initial begin
		cyc(2);
		chk("reset_hold", 6'h06);
		@(posedge clk) rstn <= 1'b1;
		cyc(1);
		chk("run", 6'h0C);
		go_sleep;
		@(posedge clk) raise <= 4'hF;
		cyc(6);
		chk("disabled_src", 6'h24);
		@(posedge clk) raise <= 4'h0;
		cyc(4);
		wake(1'b0, 4'h4, 6'h0D);
		go_sleep;
		wake(1'b1, 4'h1, 6'h0C);
		go_sleep;
		do_reset;
		go_sleep;
		@(posedge clk) hold_n <= 1'b0;
		cyc(3);
		chk("pre_standby", 6'h24);
		cyc(1);
		chk("standby", 6'h12);
		@(posedge clk) begin
			hold_n <= 1'b1;
			en <= 4'hF;
			raise <= 4'hF;
		end
		cyc(8);
		chk("standby_kept", 6'h12);
		@(posedge clk) raise <= 4'h0;
		do_reset;
		run_standby;
		do_reset;
		wrap_up;
	end
endmodule
